// ---- hw/sdsw_ctrl.sv ----
// Summary of operation
// - Critical-temperature shutdown held off while an emergency call is in progress.
// - Thermal shutdown held off during a two-minute guard window from power-up.
// - A call started within the guard window extends the deferral until it ends.
// - On guard expiry a pending shutdown is carried out, ending other activity.
// - While deferred, temperature is still sampled and alerts issued; shutdown disabled.
// - Deferral end with temperature still critical powers off at once, no new alert.
// - Second-generation interval is 4.615 ms times 51 times parameter 2..9.
// - Third-generation interval is two to the parameter times 10 ms, 6..9.
// - Fourth-generation interval is cycle value 32/64/128/256 times 10 ms.
// - Each paging cycle is a pause spent asleep then a fixed listening slot.
// - Sleep only when both serial ports idle and sleep configuration applied.
// - With expect-host-ready, sleep only when no USB transmit data pending.
// - With expect-host-ready, USB data before host readiness is discarded; default on.
// - Host falling edge on wake request ends sleep almost immediately.
// - After wake request, ready indication shows device awake and command-ready.
// - Critical alert level two leads to shutdown five seconds later unless cleared.
// - Alert levels one, minus one and zero reported as the temperature moves.
`timescale 1ns/100ps
module sdsw_ctrl
  import sdsw_pkg::*;
#(
  parameter int unsigned P_GUARD_US = GUARD_US,
  parameter int unsigned P_SHDN_US  = SHDN_US
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Thermal and call status
  input  wire logic [2:0]  i_temp_level,
  input  wire logic        i_emerg_call,
  // Port activity
  input  wire logic        i_primary_serial_port_idle,
  input  wire logic        i_secondary_serial_port_idle,
  input  wire logic [3:0]  i_usb_tx_pending,
  input  wire logic [3:0]  i_usb_data_arrive,
  // Host handshake
  input  wire logic        i_host_wake_request_n,
  output logic             o_module_ready_ind_n,
  // Power and alert outputs
  output logic             o_shutdown,
  output logic             o_sleep,
  output logic             o_listen,
  output logic             o_board_temp_alert,
  output logic      [2:0]  o_board_temp_alert_level,
  output logic      [3:0]  o_usb_discard,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  us_pre;
    logic [31:0] us_cnt;
    logic        guard_done;
    logic [4:0]  ctrl;
    logic [1:0]  rat;
    logic [8:0]  drx;
    logic [4:0]  mask;
    logic [4:0]  stat;
    sdsw_sd_e    sd;
    logic [31:0] sd_cnt;
    logic        pending;
    sdsw_sl_e    slp;
    logic [31:0] slp_cnt;
    logic        wake_q;
    logic [2:0]  lvl_q;
    logic        alert_v;
    logic [2:0]  alert_lvl;
    logic        shut;
    logic        ready_n;
    logic        sleep_o;
    logic        listen_o;
    logic [3:0]  discard;
    logic        irq;
    logic [31:0] rdata;
  } sdsw_state_s;

  sdsw_state_s st_r;
  sdsw_state_s st_nxt;

  logic        us_tick;
  logic        guard_active;
  logic        deferred;
  logic        crit;
  logic        shdn_en;
  logic        expect_rdy;
  logic        sleep_ok;
  logic        wake_fall;
  logic [31:0] interval_us;
  logic [4:0]  events;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // Derived conditions
  // ----------------------------------------------------------------
  // A call alone keeps the hold-off alive, so a call begun in the window extends it
  assign us_tick      = (st_r.us_pre == 7'(CYC_PER_US - 1));
  assign guard_active = !st_r.guard_done;
  assign deferred     = guard_active || i_emerg_call;
  assign crit         = (i_temp_level == 3'h2) || (i_temp_level == 3'h6);
  assign shdn_en      = st_r.ctrl[CTRL_SHDN_EN];
  assign expect_rdy   = st_r.ctrl[CTRL_EXPECT_RDY];
  assign wake_fall    = st_r.wake_q && !i_host_wake_request_n;
  assign interval_us  = sdsw_interval_us(st_r.rat, st_r.drx);
  // Sleep needs idle serial ports, applied config, and no USB data if gated
  assign sleep_ok     = st_r.ctrl[CTRL_SLEEP_CFG]
                        && i_primary_serial_port_idle
                        && i_secondary_serial_port_idle
                        && !(expect_rdy && (|i_usb_tx_pending))
                        && i_host_wake_request_n
                        && (st_r.sd != SD_OFF);
  assign status_word  = {21'h0, i_temp_level, st_r.slp, st_r.sd,
                         1'b0, st_r.pending, guard_active, deferred};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    events = 5'h00;

    // Free-running time base, cleared only by reset
    st_nxt.us_pre = us_tick ? 7'h00 : st_r.us_pre + 7'h01;
    if (us_tick) begin
      st_nxt.us_cnt = st_r.us_cnt + 32'h1;
    end
    if (st_r.us_cnt >= P_GUARD_US) begin
      st_nxt.guard_done = 1'b1;
    end

    // Temperature alerts keep flowing even while shutdown is held off
    st_nxt.lvl_q   = i_temp_level;
    st_nxt.alert_v = 1'b0;
    if ((i_temp_level != st_r.lvl_q) &&
        (crit || st_r.ctrl[CTRL_ALERT_PRES] || guard_active)) begin
      st_nxt.alert_v   = 1'b1;
      st_nxt.alert_lvl = i_temp_level;
      events[IRQ_ALERT] = 1'b1;
    end

    // Thermal shutdown sequencer
    case (st_r.sd)
      SD_RUN: begin
        if (crit && shdn_en) begin
          if (deferred) begin
            st_nxt.pending = 1'b1;
          end else if (st_r.pending) begin
            st_nxt.sd = SD_OFF;
          end else begin
            st_nxt.sd     = SD_WAIT;
            st_nxt.sd_cnt = 32'(P_SHDN_US - 1);
          end
        end else begin
          st_nxt.pending = 1'b0;
        end
      end
      SD_WAIT: begin
        if (!crit || !shdn_en) begin
          st_nxt.sd = SD_RUN;
        end else if (deferred) begin
          st_nxt.sd      = SD_RUN;
          st_nxt.pending = 1'b1;
        end else if (us_tick) begin
          if (st_r.sd_cnt == 32'h0) begin
            st_nxt.sd = SD_OFF;
          end else begin
            st_nxt.sd_cnt = st_r.sd_cnt - 32'h1;
          end
        end
      end
      SD_OFF: begin
        st_nxt.sd = SD_OFF;
      end
      default: begin
        st_nxt.sd = SD_RUN;
      end
    endcase
    if ((st_nxt.sd == SD_OFF) && (st_r.sd != SD_OFF)) begin
      events[IRQ_SHDN] = 1'b1;
    end
    st_nxt.shut = (st_nxt.sd == SD_OFF);

    // Sleep and paging sequencer
    st_nxt.wake_q = i_host_wake_request_n;
    case (st_r.slp)
      SL_AWAKE: begin
        if (sleep_ok) begin
          st_nxt.slp     = SL_PAUSE;
          st_nxt.slp_cnt = interval_us - 32'(LISTEN_US) - 32'h1;
        end
      end
      SL_PAUSE: begin
        if (wake_fall || !sleep_ok) begin
          st_nxt.slp = SL_AWAKE;
        end else if (us_tick) begin
          if (st_r.slp_cnt == 32'h0) begin
            st_nxt.slp     = SL_LISTEN;
            st_nxt.slp_cnt = 32'(LISTEN_US - 1);
            events[IRQ_LISTEN] = 1'b1;
          end else begin
            st_nxt.slp_cnt = st_r.slp_cnt - 32'h1;
          end
        end
      end
      SL_LISTEN: begin
        if (wake_fall || !sleep_ok) begin
          st_nxt.slp = SL_AWAKE;
        end else if (us_tick) begin
          if (st_r.slp_cnt == 32'h0) begin
            st_nxt.slp     = SL_PAUSE;
            st_nxt.slp_cnt = interval_us - 32'(LISTEN_US) - 32'h1;
          end else begin
            st_nxt.slp_cnt = st_r.slp_cnt - 32'h1;
          end
        end
      end
      default: begin
        st_nxt.slp = SL_AWAKE;
      end
    endcase
    if (wake_fall && (st_r.slp != SL_AWAKE)) begin
      events[IRQ_WAKE] = 1'b1;
    end
    // Ready only while awake and powered; low means ready
    st_nxt.ready_n = !((st_nxt.slp == SL_AWAKE) && (st_nxt.sd != SD_OFF));
    // Sleep and listen flags kept in flops so the pins never see decode glitches
    st_nxt.sleep_o  = (st_nxt.slp == SL_PAUSE);
    st_nxt.listen_o = (st_nxt.slp == SL_LISTEN);

    // USB data arriving before the host is ready is dropped
    st_nxt.discard = (expect_rdy && !st_r.ctrl[CTRL_HOST_RDY]) ?
                     i_usb_data_arrive : 4'h0;
    events[IRQ_DISCARD] = |st_nxt.discard;

    // Register writes; invalid reception parameters are ignored
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL:  st_nxt.ctrl = i_wdata[4:0];
        ADDR_IMASK: st_nxt.mask = i_wdata[4:0];
        ADDR_RAT: begin
          if (sdsw_drx_valid(i_wdata[RAT_SEL_LSB +: 2], i_wdata[RAT_DRX_LSB +: 9])) begin
            st_nxt.rat = i_wdata[RAT_SEL_LSB +: 2];
            st_nxt.drx = i_wdata[RAT_DRX_LSB +: 9];
          end
        end
        default: begin
        end
      endcase
    end

    // Reads; interrupt status read clears, but a same-cycle event still lands
    st_nxt.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:   st_nxt.rdata = {27'h0, st_r.ctrl};
        ADDR_RAT:    st_nxt.rdata = {14'h0, st_r.rat, 7'h0, st_r.drx};
        ADDR_STATUS: st_nxt.rdata = status_word;
        ADDR_ISTAT:  st_nxt.rdata = {27'h0, st_r.stat};
        ADDR_IMASK:  st_nxt.rdata = {27'h0, st_r.mask};
        ADDR_TBASE:  st_nxt.rdata = st_r.us_cnt;
        ADDR_ALERT:  st_nxt.rdata = {29'h0, st_r.alert_lvl};
        default:     st_nxt.rdata = 32'h0;
      endcase
    end
    st_nxt.stat = ((i_rd && (i_addr == ADDR_ISTAT)) ? 5'h00 : st_r.stat) | events;
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st_r           <= '0;
      st_r.ctrl      <= CTRL_RST;
      st_r.drx       <= DRX_RST;
      st_r.mask      <= IMASK_RST;
      st_r.sd        <= SD_RUN;
      st_r.slp       <= SL_AWAKE;
      st_r.wake_q    <= 1'b1;
      st_r.ready_n   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_rdata                  = st_r.rdata;
  assign o_module_ready_ind_n     = st_r.ready_n;
  assign o_shutdown               = st_r.shut;
  assign o_sleep                  = st_r.sleep_o;
  assign o_listen                 = st_r.listen_o;
  assign o_board_temp_alert       = st_r.alert_v;
  assign o_board_temp_alert_level = st_r.alert_lvl;
  assign o_usb_discard            = st_r.discard;
  assign o_irq                    = st_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_call_held;
    (i_emerg_call && st_r.sd != SD_OFF) ##1 i_emerg_call [*2];
  endsequence

  sequence s_enter_pause;
    (st_r.slp == SL_AWAKE) ##1 (st_r.slp == SL_PAUSE);
  endsequence

  a_defer_no_off: assert property (
    (deferred && st_r.sd != SD_OFF) |=> (st_r.sd != SD_OFF))
    else $error("shutdown taken while deferred");

  a_guard_window: assert property (
    !st_r.guard_done |-> (st_r.us_cnt <= P_GUARD_US))
    else $error("guard window outlived its time base count");

  a_call_extends: assert property (s_call_held |-> (st_r.sd != SD_OFF))
    else $error("shutdown during ongoing emergency call");

  a_resume_off: assert property (
    (st_r.sd == SD_RUN && st_r.pending && crit && shdn_en && !deferred
     && $stable(i_temp_level)) |=> (st_r.sd == SD_OFF && st_r.shut && !st_r.alert_v))
    else $error("pending shutdown not immediate or alert repeated");

  a_alert_while: assert property (
    (deferred && crit && i_temp_level != st_r.lvl_q)
    |=> (st_r.alert_v && st_r.alert_lvl == $past(i_temp_level)))
    else $error("critical alert missing during deferral");

  a_crit_delay: assert property (
    (st_r.sd == SD_RUN && crit && shdn_en && !deferred && !st_r.pending)
    |=> (st_r.sd == SD_WAIT && st_r.sd_cnt == 32'(P_SHDN_US - 1)))
    else $error("five second countdown not started");

  a_interval_load: assert property (s_enter_pause
    |-> (st_r.slp_cnt == $past(interval_us) - 32'(LISTEN_US) - 32'h1))
    else $error("sleep interval loaded wrong");

  a_listen_len: assert property (
    (st_r.slp == SL_PAUSE ##1 st_r.slp == SL_LISTEN)
    |-> (st_r.slp_cnt == 32'(LISTEN_US - 1)))
    else $error("listening slot length wrong");

  a_sleep_gate: assert property (
    (st_r.slp == SL_AWAKE && !sleep_ok) |=> (st_r.slp == SL_AWAKE))
    else $error("sleep entered while not allowed");

  a_usb_discard: assert property (
    (expect_rdy && !st_r.ctrl[CTRL_HOST_RDY] && i_usb_data_arrive[0])
    |=> o_usb_discard[0])
    else $error("early USB data not discarded");

  a_wake_ready: assert property (
    (wake_fall && st_r.slp != SL_AWAKE && st_r.sd != SD_OFF)
    |=> (st_r.slp == SL_AWAKE && !o_module_ready_ind_n))
    else $error("wake request not answered by ready indication");

endmodule : sdsw_ctrl

// ---- hw/sdsw_pkg.sv ----
package sdsw_pkg;

  // ----------------------------------------------------------------
  // Clock and time units
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int GUARD_MIN     = 2;
  localparam int GUARD_US      = GUARD_MIN * 60 * 1000000;
  localparam int SHDN_S        = 5;
  localparam int SHDN_US       = SHDN_S * 1000000;
  localparam int LISTEN_MS     = 10;
  localparam int LISTEN_US     = LISTEN_MS * 1000;
  localparam int GSM_FRAME_US  = 4615;
  localparam int GSM_FRAMES    = 51;
  localparam int WCDMA_FRAME_MS = 10;
  localparam int LTE_UNIT_MS   = 10;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RAT    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ISTAT  = 8'h0C;
  localparam logic [7:0] ADDR_IMASK  = 8'h10;
  localparam logic [7:0] ADDR_TBASE  = 8'h14;
  localparam logic [7:0] ADDR_ALERT  = 8'h18;

  // Control register bits
  localparam int CTRL_SLEEP_CFG  = 0;
  localparam int CTRL_EXPECT_RDY = 1;
  localparam int CTRL_ALERT_PRES = 2;
  localparam int CTRL_SHDN_EN    = 3;
  localparam int CTRL_HOST_RDY   = 4;
  localparam logic [4:0] CTRL_RST = 5'h0A;

  // Access type register fields
  localparam int RAT_DRX_LSB = 0;
  localparam int RAT_SEL_LSB = 16;
  localparam logic [8:0] DRX_RST = 9'h002;

  // Interrupt status bits
  localparam int IRQ_ALERT   = 0;
  localparam int IRQ_SHDN    = 1;
  localparam int IRQ_WAKE    = 2;
  localparam int IRQ_LISTEN  = 3;
  localparam int IRQ_DISCARD = 4;
  localparam logic [4:0] IMASK_RST = 5'h00;

  typedef enum logic [1:0] {RAT_GSM, RAT_WCDMA, RAT_LTE} sdsw_rat_e;
  typedef enum logic [1:0] {SD_RUN, SD_WAIT, SD_OFF} sdsw_sd_e;
  typedef enum logic [1:0] {SL_AWAKE, SL_PAUSE, SL_LISTEN} sdsw_sl_e;

  // Sleep interval in microseconds for the current access type
  function automatic logic [31:0] sdsw_interval_us(input logic [1:0] rat,
                                                   input logic [8:0] drx);
    case (rat)
      RAT_GSM:   sdsw_interval_us = 32'(GSM_FRAME_US * GSM_FRAMES * int'(drx));
      RAT_WCDMA: sdsw_interval_us = 32'(WCDMA_FRAME_MS * 1000) << drx[3:0];
      default:   sdsw_interval_us = 32'(LTE_UNIT_MS * 1000 * int'(drx));
    endcase
  endfunction : sdsw_interval_us

  // Reception parameter range check per access type
  function automatic logic sdsw_drx_valid(input logic [1:0] rat,
                                          input logic [8:0] drx);
    case (rat)
      RAT_GSM:   sdsw_drx_valid = (drx >= 9'h002) && (drx <= 9'h009);
      RAT_WCDMA: sdsw_drx_valid = (drx >= 9'h006) && (drx <= 9'h009);
      RAT_LTE:   sdsw_drx_valid = (drx == 9'h020) || (drx == 9'h040) ||
                                  (drx == 9'h080) || (drx == 9'h100);
      default:   sdsw_drx_valid = 1'b0;
    endcase
  endfunction : sdsw_drx_valid

endpackage : sdsw_pkg

// ---- dv/sdsw_host_model.sv ----
`timescale 1ns/100ps
module sdsw_host_model (
  // Clock
  input  wire logic i_core_clk,
  // Wake command and device readiness
  input  wire logic i_wake_go,
  input  wire logic i_module_ready_ind_n,
  // Wake line and readiness count
  output logic      o_host_wake_request_n,
  output int        o_ready_seen
);
  logic wake_n_r = 1'b1;
  int   hold_cnt = 0;
  int   seen_cnt = 0;

  // ----------------------------------------------------------------
  // Wake line driver
  // ----------------------------------------------------------------
  // Pull low on command, wait for readiness, hold eight more cycles
  always @(posedge i_core_clk) begin
    if (i_wake_go && wake_n_r) begin
      wake_n_r <= 1'b0;
      hold_cnt <= 8;
    end else if (!wake_n_r && (hold_cnt < 8 || i_module_ready_ind_n === 1'b0)) begin
      if (hold_cnt == 8) seen_cnt <= seen_cnt + 1;
      if (hold_cnt == 0) wake_n_r <= 1'b1;
      hold_cnt <= hold_cnt - 1;
    end
  end

  assign o_host_wake_request_n = wake_n_r;
  assign o_ready_seen          = seen_cnt;
endmodule : sdsw_host_model

// ---- dv/tb_shutdown_defer_sleep_wake_ctrl.sv ----
`timescale 1ns/100ps
module tb_shutdown_defer_sleep_wake_ctrl;
  import sdsw_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rstn, wr, rd, emerg, idle0, idle1, wake_n, ready_n, wake_go;
  logic        sd, slp, lsn, alrt, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, a;
  logic [2:0]  temp, alvl;
  logic [3:0]  usb_pend, usb_arr, disc, disc_seen;
  int          err_total = 0, n_checks = 0, n_alert = 0, n_disc = 0, cyc = 0, t0, n;
  int          ready_seen;
  logic [31:0] rat_w [7] = '{32'h9, 32'h1, 32'h10006, 32'h1000A, 32'h20100, 32'h20041,
                             32'h20020};
  logic [31:0] rat_e [7] = '{32'h9, 32'h9, 32'h10006, 32'h10006, 32'h20100, 32'h20100,
                             32'h20020};
  logic [2:0]  lvl [3] = '{3'h1, 3'h7, 3'h0};

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  // Short guard and countdown so a full deferral fits in the run
  sdsw_ctrl #(.P_GUARD_US(200), .P_SHDN_US(20)) u_dut (
    .i_core_clk                   (clk),
    .i_rstn                       (rstn),
    .i_addr                       (addr),
    .i_wdata                      (wdata),
    .i_wr                         (wr),
    .i_rd                         (rd),
    .o_rdata                      (rdata),
    .i_temp_level                 (temp),
    .i_emerg_call                 (emerg),
    .i_primary_serial_port_idle   (idle0),
    .i_secondary_serial_port_idle (idle1),
    .i_usb_tx_pending             (usb_pend),
    .i_usb_data_arrive            (usb_arr),
    .i_host_wake_request_n        (wake_n),
    .o_module_ready_ind_n         (ready_n),
    .o_shutdown                   (sd),
    .o_sleep                      (slp),
    .o_listen                     (lsn),
    .o_board_temp_alert           (alrt),
    .o_board_temp_alert_level     (alvl),
    .o_usb_discard                (disc),
    .o_irq                        (irq)
  );

  sdsw_host_model u_host (
    .i_core_clk            (clk),
    .i_wake_go             (wake_go),
    .i_module_ready_ind_n  (ready_n),
    .o_host_wake_request_n (wake_n),
    .o_ready_seen          (ready_seen)
  );

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Time-zero values for every input
  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; temp = 3'h0;
    emerg = 1'b0; idle0 = 1'b1; idle1 = 1'b1; usb_pend = 4'h0; usb_arr = 4'h0;
    wake_go = 1'b0;
  end

  // Pulse counters, cleared by each reset so runs stay independent
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rstn) begin
      n_alert   <= 0;
      n_disc    <= 0;
      disc_seen <= 4'h0;
    end else begin
      if (alrt === 1'b1) n_alert <= n_alert + 1;
      if (disc !== 4'h0) n_disc <= n_disc + 1;
      disc_seen <= disc_seen | disc;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= ad;
    wdata <= dt;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    dt = rdata;
  endtask : rd_reg

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic do_reset();
    rstn  <= 1'b0;
    temp  <= 3'h0;
    emerg <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t0 = cyc;
    @(posedge clk);
  endtask : do_reset

  task automatic wait_sd(input int lim, output int k);
    k = 0;
    while (sd !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask : wait_sd

  // Watchdog, well past the expected length of all tests
  initial begin
    #900000;
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd_reg(ADDR_TBASE, a);
    check(a, 32'h0);
    rd_reg(ADDR_CTRL, d);
    check(d, 32'h0000000A);
    wr_reg(8'h1C, 32'hFFFFFFFF);
    rd_reg(8'h1C, d);
    check(d, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr_reg(ADDR_RAT, rat_w[i]);
      rd_reg(ADDR_RAT, d);
      check(d, rat_e[i]);
    end
    rd_reg(ADDR_TBASE, a);
    repeat (1000) @(posedge clk);
    rd_reg(ADDR_TBASE, d);
    check(32'(d - a >= 9 && d - a <= 11), 32'h1);
    // Pauses outlast this run, so only sleep entry and wake are seen
    wr_reg(ADDR_CTRL, 32'h0000000B);
    tick(3);
    check(32'({slp, ready_n}), 32'h3);
    @(posedge clk) idle1 <= 1'b0;
    tick(3);
    check(32'(slp), 32'h0);
    @(posedge clk) idle0 <= 1'b0;
    idle1 <= 1'b1;
    tick(3);
    check(32'(slp), 32'h0);
    @(posedge clk) idle0 <= 1'b1;
    @(posedge clk) usb_pend <= 4'h4;
    tick(3);
    check(32'(slp), 32'h0);
    @(posedge clk) usb_pend <= 4'h0;
    tick(3);
    check(32'(slp), 32'h1);
    @(posedge clk) wake_go <= 1'b1;
    @(posedge clk) wake_go <= 1'b0;
    tick(4);
    check(32'({slp, lsn, ready_n}), 32'h0);
    wr_reg(ADDR_CTRL, 32'h0000000A);
    tick(20);
    check(ready_seen, 1);
    @(posedge clk) usb_arr <= 4'h2;
    @(posedge clk) usb_arr <= 4'h0;
    tick(3);
    check(n_disc, 1);
    check(32'(disc_seen), 32'h2);
    rd_reg(ADDR_ISTAT, d);
    check(d, 32'h14);
    wr_reg(ADDR_CTRL, 32'h0000001A);
    @(posedge clk) usb_arr <= 4'h2;
    @(posedge clk) usb_arr <= 4'h0;
    tick(3);
    check(n_disc, 1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) temp <= lvl[i];
      tick(3);
      check(32'(alvl), 32'(lvl[i]));
    end
    check(n_alert, 3);
    @(posedge clk) temp <= 3'h2;
    tick(3);
    rd_reg(ADDR_STATUS, d);
    check(d & 32'h7, 32'h7);
    check(32'(irq), 32'h0);
    wait_sd(30000, n);
    check(32'(cyc - t0 >= 19900 && cyc - t0 <= 20300), 32'h1);
    check(n_alert, 4);
    // A call begun in the guard window holds the deferral past it
    do_reset();
    wr_reg(ADDR_IMASK, 32'h0000001F);
    @(posedge clk) emerg <= 1'b1;
    @(posedge clk) temp <= 3'h2;
    repeat (21000) @(posedge clk);
    @(posedge clk) temp <= 3'h6;
    tick(3);
    check(32'(sd), 32'h0);
    check(32'(alvl), 32'h6);
    @(posedge clk) emerg <= 1'b0;
    tick(3);
    check(32'(sd), 32'h1);
    check(n_alert, 2);
    check(32'(irq), 32'h1);
    rd_reg(ADDR_ISTAT, d);
    check(d, 32'h3);
    rd_reg(ADDR_ISTAT, d);
    check(d, 32'h0);
    tick(3);
    check(32'(irq), 32'h0);
    // Countdown after the guard: cancelled, then carried out
    do_reset();
    repeat (20500) @(posedge clk);
    @(posedge clk) temp <= 3'h2;
    repeat (1000) @(posedge clk);
    @(posedge clk) temp <= 3'h0;
    tick(2500);
    check(32'(sd), 32'h0);
    check(n_alert, 1);
    // Presentation switched on after the guard: a non-critical level shows again
    wr_reg(ADDR_CTRL, 32'h0000000E);
    @(posedge clk) temp <= 3'h1;
    tick(3);
    check(n_alert, 2);
    @(posedge clk) temp <= 3'h6;
    tick(1);
    wait_sd(3000, n);
    check(32'(n >= 1900 && n <= 2200), 32'h1);
    close_out();
  end
endmodule : tb_shutdown_defer_sleep_wake_ctrl
